// ---- pkg/eth_func_regs.vh ----
// Constants for the USB Ethernet function with wake logic
`ifndef ETH_FUNC_REGS_VH
`define ETH_FUNC_REGS_VH
`define CLK_MHZ 100
`define SUSP_TIME_US 3000
`define PAUSE_BITS 512
`define RATE100_MBPS 100
`define RATE10_MBPS 10
`define SYNC_N 6
`define SY_LINK 0
`define SY_ACT 1
`define SY_SPWR 2
`define SY_POLR 3
`define SY_SPD 4
`define SY_FDX 5
`define RT_DEV_IN 8'h80
`define RT_IF_IN 8'h81
`define RT_EP_IN 8'h82
`define RT_DEV_OUT 8'h00
`define RT_EP_OUT 8'h02
`define RT_CLS_OUT 8'h21
`define RT_CLS_IN 8'ha1
`define RT_VND_IN 8'hc0
`define RQ_GET_STAT 8'h00
`define RQ_CLR_FEAT 8'h01
`define RQ_SET_FEAT 8'h03
`define RQ_SET_ADDR 8'h05
`define RQ_GET_CFG 8'h08
`define RQ_SET_CFG 8'h09
`define RQ_MCAST 8'h40
`define RQ_PKT_FLT 8'h43
`define RQ_STAT 8'h44
`define RQ_CHIP_ID 8'hff
`define FEAT_RWAKE 16'h0001
`define ADDR_MAX 16'h007f
`define CFG_MAX 16'h0001
`define PF_PROMISC 0
`define PF_ALLMC 1
`define PF_DIRECT 2
`define PF_BCAST 3
`define PF_MCAST 4
`define PF_RESET 16'h001c
`define MC_N 4
`define MC_AW 2
`define MAC_BYTES 16'h0006
`define STAT_TX_OK 16'h0001
`define STAT_RX_OK 16'h0002
`define STAT_RX_CRC 16'h0012
`define LEN_STAT 3'h2
`define LEN_CFG 3'h1
`define LEN_CNT 3'h4
`define LEN_ID 3'h6
`define CRC_POLY 32'hedb88320
`define CRC_INIT 32'hffffffff
`define CRC_RESID 32'hdebb20e3
`define MAGIC_FF 8'hff
`define MAGIC_NFF 3'h6
`define MAGIC_REPS 4'hf
`define BCAST_DA 48'hffffffffffff
`define PAUSE_DA 48'h0180c2000001
`define PAUSE_TAG 32'h88080001
`define HDR_END 11'h012
`define DA_END 11'h006
`define FCS_DLY 11'h004
`define IP_START 11'h00e
`define IDX_MAX 11'h7ff
`define FIFO_W 9
`define FIFO_D 16
`define FIFO_AW 4
`endif

// ---- hdl/fifo_sync.v ----
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module fifo_sync #(
  parameter W  = 9,
  parameter D  = 16,
  parameter AW = 4
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         rstn_i,
  input  wire         ce_i,
  // Fill side
  input  wire         in_vld_i,
  input  wire [W-1:0] in_data_i,
  output reg          in_rdy_o,
  // Drain side
  output reg          out_vld_o,
  output wire [W-1:0] out_data_o,
  input  wire         out_rdy_i
);
  reg  [W-1:0] mem [0:D-1];
  reg  [AW-1:0] wp_r;
  reg  [AW-1:0] rp_r;
  reg  [AW:0]   cnt_r;
  wire          push = in_vld_i & in_rdy_o;
  wire          pop  = out_vld_o & out_rdy_i;
  wire [AW:0]   cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  wire [AW:0]   depth = D[AW:0];

  assign out_data_o = mem[rp_r];

  always @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[wp_r] <= in_data_i;
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_r      <= {AW{1'b0}};
      rp_r      <= {AW{1'b0}};
      cnt_r     <= {(AW+1){1'b0}};
      in_rdy_o  <= 1'b0;
      out_vld_o <= 1'b0;
    end else if (ce_i) begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r     <= cnt_nxt;
      in_rdy_o  <= (cnt_nxt != depth);
      out_vld_o <= (cnt_nxt != {(AW+1){1'b0}});
    end
  end
endmodule

// ---- hdl/eth_func_wake.v ----
// Ethernet function: MAC datapath, filtering, control requests, suspend and wake
`timescale 1ns/100ps
`include "eth_func_regs.vh"
module eth_func_wake #(
  parameter [18:0] SUSP_CYC     = `SUSP_TIME_US * `CLK_MHZ,
  parameter [12:0] PAUSE_SLOT10 = `PAUSE_BITS * `CLK_MHZ / `RATE10_MBPS,
  // Arbitrary identification value
  parameter [47:0] CHIP_ID      = 48'h000100020003
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rstn_i,
  input  wire        ce_i,
  // Asynchronous pins and straps
  input  wire        link_up_i,
  input  wire        bus_act_i,
  input  wire        self_pwr_i,
  input  wire        pol_rev_i,
  input  wire        an_spd100_i,
  input  wire        an_fdx_i,
  // Static configuration
  input  wire [47:0] mac_addr_i,
  input  wire        pause_honor_i,
  // Control endpoint
  input  wire        setup_vld_i,
  input  wire [7:0]  bm_req_type_i,
  input  wire [7:0]  b_req_i,
  input  wire [15:0] w_value_i,
  input  wire [15:0] w_length_i,
  input  wire        ctl_wvld_i,
  input  wire [7:0]  ctl_wdata_i,
  output reg         ctl_done_o,
  output reg         ctl_stall_o,
  output reg  [47:0] ctl_rdata_o,
  output reg  [2:0]  ctl_rlen_o,
  output reg  [6:0]  dev_addr_o,
  output reg         cfg_o,
  // Transmit from host
  input  wire        tx_vld_i,
  input  wire [7:0]  tx_data_i,
  input  wire        tx_last_i,
  output wire        tx_rdy_o,
  // Transmit to PHY
  output reg         tx_en_o,
  output reg  [7:0]  tx_data_o,
  input  wire        tx_ack_i,
  // Receive from PHY
  input  wire        rx_dv_i,
  input  wire [7:0]  rx_data_i,
  // Receive results
  output reg         rx_acc_o,
  output reg         rx_err_o,
  output reg  [15:0] rx_csum_o,
  // PHY control and power state
  output reg         speed100_o,
  output reg         full_dup_o,
  output reg         pol_fix_o,
  output reg         mdix_en_o,
  output reg         phy_pwr_o,
  output reg         suspend_o,
  output reg         resume_o,
  output reg         rwake_o
);
  localparam [1:0] T_IDLE = 2'd0;
  localparam [1:0] T_DATA = 2'd1;
  localparam [1:0] T_FCS  = 2'd2;
  localparam       C_IDLE = 1'b0;
  localparam       C_MC   = 1'b1;
  localparam [12:0] SLOT100 = `PAUSE_BITS * `CLK_MHZ / `RATE100_MBPS;

  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0]  d;
    integer      i;
    reg   [31:0] r;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1) begin
        r = (r[0] ^ d[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
      end
      crc_byte = r;
    end
  endfunction

  // Pin synchronisers, three stages, change taken when stages two and three agree
  wire [`SYNC_N-1:0] pin_a = {an_fdx_i, an_spd100_i, pol_rev_i, self_pwr_i, bus_act_i, link_up_i};
  wire [`SYNC_N-1:0] pin_s;
  genvar g;
  generate
    for (g = 0; g < `SYNC_N; g = g + 1) begin : g_sync
      reg s1;
      reg s2;
      reg s3;
      reg sc;
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          sc <= 1'b0;
        end else if (ce_i) begin
          s1 <= pin_a[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            sc <= s3;
          end
        end
      end
      assign pin_s[g] = sc;
    end
  endgenerate
  wire link_s = pin_s[`SY_LINK];
  wire act_s  = pin_s[`SY_ACT];
  wire spwr_s = pin_s[`SY_SPWR];

  // Transmit buffer in on-chip memory
  wire [8:0] fo_data;
  wire       fo_vld;
  wire       fo_rdy;
  fifo_sync #(.W(`FIFO_W), .D(`FIFO_D), .AW(`FIFO_AW)) u_txq (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .ce_i       (ce_i),
    .in_vld_i   (tx_vld_i),
    .in_data_i  ({tx_last_i, tx_data_i}),
    .in_rdy_o   (tx_rdy_o),
    .out_vld_o  (fo_vld),
    .out_data_o (fo_data),
    .out_rdy_i  (fo_rdy)
  );

  // Multicast table
  reg [47:0]      mc_tab [0:`MC_N-1];
  reg [15:0]      mc_cnt_r;
  reg [47:0]      mc_sh_r;
  reg [2:0]       mc_b_r;
  reg [`MC_AW-1:0] mc_e_r;
  reg             ctl_st_r;
  reg [15:0]      pf_r;
  wire [47:0]     mc_word = {mc_sh_r[39:0], ctl_wdata_i};
  wire            mc_wr = ctl_st_r == C_MC && ctl_wvld_i && mc_b_r == 3'd5;
  always @(posedge clk_i) begin
    if (ce_i && mc_wr) begin
      mc_tab[mc_e_r] <= mc_word;
    end
  end

  // Receive state
  reg         rx_dv_d;
  reg [10:0]  idx_r;
  reg [31:0]  rcrc_r;
  reg [47:0]  da_r;
  reg [47:0]  hdr_r;
  reg [31:0]  dly_r;
  reg [7:0]   hi_r;
  reg [15:0]  sum_r;
  reg [2:0]   mg_ff_r;
  reg [2:0]   mg_b_r;
  reg [3:0]   mg_n_r;
  reg         mg_hit_r;
  reg [31:0]  st_tx_r;
  reg [31:0]  st_rx_r;
  reg [31:0]  st_crc_r;
  reg [15:0]  pq_r;
  reg [12:0]  slot_r;
  reg         magic_ev;

  wire [`MC_N-1:0] mc_hit;
  generate
    for (g = 0; g < `MC_N; g = g + 1) begin : g_mc
      assign mc_hit[g] = (g < mc_cnt_r) && (mc_tab[g] == da_r);
    end
  endgenerate

  wire        is_bc  = da_r == `BCAST_DA;
  wire        is_mc  = da_r[40] & ~is_bc;
  wire        da_ok  = pf_r[`PF_PROMISC] |
                       (pf_r[`PF_DIRECT] & (da_r == mac_addr_i)) |
                       (pf_r[`PF_BCAST] & is_bc) |
                       (is_mc & (pf_r[`PF_ALLMC] | (pf_r[`PF_MCAST] & (|mc_hit))));
  wire        rx_end = rx_dv_d & ~rx_dv_i;
  wire        fcs_ok = rcrc_r == `CRC_RESID;
  wire [10:0] pos    = idx_r - `FCS_DLY;
  wire [16:0] sum_w  = {1'b0, sum_r} + {1'b0, hi_r, dly_r[31:24]};
  wire [7:0]  mac_b  = mac_addr_i[6'd47 - {mg_b_r, 3'b000} -: 8];
  wire        mg_arm = mg_ff_r == `MAGIC_NFF;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_dv_d  <= 1'b0;
      idx_r    <= 11'h000;
      rcrc_r   <= `CRC_INIT;
      da_r     <= 48'h000000000000;
      hdr_r    <= 48'h000000000000;
      dly_r    <= 32'h00000000;
      hi_r     <= 8'h00;
      sum_r    <= 16'h0000;
      mg_ff_r  <= 3'h0;
      mg_b_r   <= 3'h0;
      mg_n_r   <= 4'h0;
      mg_hit_r <= 1'b0;
      rx_acc_o <= 1'b0;
      rx_err_o <= 1'b0;
      rx_csum_o <= 16'h0000;
      st_rx_r  <= 32'h00000000;
      st_crc_r <= 32'h00000000;
      magic_ev <= 1'b0;
    end else if (ce_i) begin
      rx_dv_d  <= rx_dv_i;
      rx_acc_o <= 1'b0;
      rx_err_o <= 1'b0;
      magic_ev <= 1'b0;
      if (rx_dv_i) begin
        rcrc_r <= crc_byte(rcrc_r, rx_data_i);
        dly_r  <= {dly_r[23:0], rx_data_i};
        if (idx_r != `IDX_MAX) begin
          idx_r <= idx_r + 11'h001;
        end
        if (idx_r < `DA_END) begin
          da_r <= {da_r[39:0], rx_data_i};
        end
        if (idx_r < `HDR_END) begin
          hdr_r <= {hdr_r[39:0], rx_data_i};
        end
        if (idx_r >= `FCS_DLY + `IP_START && idx_r != `IDX_MAX) begin
          if (!pos[0]) begin
            hi_r <= dly_r[31:24];
          end else begin
            sum_r <= sum_w[15:0] + {15'h0000, sum_w[16]};
          end
        end
        if (mg_arm && rx_data_i == mac_b) begin
          mg_b_r <= (mg_b_r == 3'd5) ? 3'd0 : mg_b_r + 3'd1;
          if (mg_b_r == 3'd5) begin
            mg_n_r <= mg_n_r + 4'h1;
            if (mg_n_r == `MAGIC_REPS) begin
              mg_hit_r <= 1'b1;
              mg_ff_r  <= 3'h0;
            end
          end
        end else if (rx_data_i == `MAGIC_FF) begin
          mg_b_r  <= 3'h0;
          mg_n_r  <= 4'h0;
          if (mg_b_r != 3'h0 || mg_n_r != 4'h0) begin
            mg_ff_r <= 3'h1;
          end else if (!mg_arm) begin
            mg_ff_r <= mg_ff_r + 3'h1;
          end
        end else begin
          mg_ff_r <= 3'h0;
          mg_b_r  <= 3'h0;
          mg_n_r  <= 4'h0;
        end
      end else begin
        idx_r    <= 11'h000;
        rcrc_r   <= `CRC_INIT;
        sum_r    <= 16'h0000;
        mg_ff_r  <= 3'h0;
        mg_b_r   <= 3'h0;
        mg_n_r   <= 4'h0;
        mg_hit_r <= 1'b0;
      end
      if (rx_end) begin
        rx_acc_o  <= fcs_ok & da_ok;
        rx_err_o  <= ~fcs_ok;
        rx_csum_o <= ~sum_r;
        magic_ev  <= fcs_ok & mg_hit_r;
        if (fcs_ok && da_ok) begin
          st_rx_r <= st_rx_r + 32'h00000001;
        end
        if (!fcs_ok) begin
          st_crc_r <= st_crc_r + 32'h00000001;
        end
      end
    end
  end

  // Pause timer from received pause frames
  wire [12:0] slot_len = speed100_o ? SLOT100 : PAUSE_SLOT10;
  wire        pause_rx = rx_end & fcs_ok & pause_honor_i & (da_r == `PAUSE_DA) &
                         (hdr_r[47:16] == `PAUSE_TAG);
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pq_r   <= 16'h0000;
      slot_r <= 13'h0000;
    end else if (ce_i) begin
      if (pause_rx) begin
        pq_r   <= hdr_r[15:0];
        slot_r <= 13'h0000;
      end else if (pq_r != 16'h0000) begin
        if (slot_r == slot_len - 13'h0001) begin
          slot_r <= 13'h0000;
          pq_r   <= pq_r - 16'h0001;
        end else begin
          slot_r <= slot_r + 13'h0001;
        end
      end
    end
  end

  // Transmit engine with FCS append
  reg  [1:0]  tst_r;
  reg         tlast_r;
  reg  [31:0] tcrc_r;
  reg  [31:0] fcs_r;
  reg  [1:0]  fcs_n_r;
  wire [31:0] tcrc_n = crc_byte(tcrc_r, tx_data_o);
  wire        t_go   = fo_vld & link_s & (pq_r == 16'h0000);
  assign fo_rdy = (tst_r == T_IDLE && t_go) ||
                  (tst_r == T_DATA && fo_vld && !tlast_r && (!tx_en_o || tx_ack_i));
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tst_r     <= T_IDLE;
      tlast_r   <= 1'b0;
      tcrc_r    <= `CRC_INIT;
      fcs_r     <= 32'h00000000;
      fcs_n_r   <= 2'h0;
      tx_en_o   <= 1'b0;
      tx_data_o <= 8'h00;
      st_tx_r   <= 32'h00000000;
    end else if (ce_i) begin
      case (tst_r)
        T_IDLE: begin
          tcrc_r <= `CRC_INIT;
          if (fo_rdy) begin
            tx_data_o <= fo_data[7:0];
            tlast_r   <= fo_data[8];
            tx_en_o   <= 1'b1;
            tst_r     <= T_DATA;
          end
        end
        T_DATA: begin
          if (tx_en_o && tx_ack_i) begin
            tcrc_r <= tcrc_n;
          end
          if (fo_rdy) begin
            tx_data_o <= fo_data[7:0];
            tlast_r   <= fo_data[8];
            tx_en_o   <= 1'b1;
          end else if (tx_en_o && tx_ack_i && tlast_r) begin
            fcs_r     <= ~tcrc_n;
            tx_data_o <= ~tcrc_n[7:0];
            fcs_n_r   <= 2'h0;
            tst_r     <= T_FCS;
          end else if (tx_en_o && tx_ack_i) begin
            tx_en_o <= 1'b0;
          end
        end
        T_FCS: begin
          if (tx_ack_i) begin
            fcs_n_r   <= fcs_n_r + 2'h1;
            fcs_r     <= {8'h00, fcs_r[31:8]};
            tx_data_o <= fcs_r[15:8];
            if (fcs_n_r == 2'h3) begin
              tx_en_o <= 1'b0;
              tst_r   <= T_IDLE;
              st_tx_r <= st_tx_r + 32'h00000001;
            end
          end
        end
        default: begin
          tst_r <= T_IDLE;
        end
      endcase
    end
  end

  // Control endpoint requests
  wire [15:0] req = {bm_req_type_i, b_req_i};
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctl_st_r    <= C_IDLE;
      ctl_done_o  <= 1'b0;
      ctl_stall_o <= 1'b0;
      ctl_rdata_o <= 48'h000000000000;
      ctl_rlen_o  <= 3'h0;
      dev_addr_o  <= 7'h00;
      cfg_o       <= 1'b0;
      rwake_o     <= 1'b0;
      pf_r        <= `PF_RESET;
      mc_cnt_r    <= 16'h0000;
      mc_sh_r     <= 48'h000000000000;
      mc_b_r      <= 3'h0;
      mc_e_r      <= {`MC_AW{1'b0}};
    end else if (ce_i) begin
      ctl_done_o  <= 1'b0;
      ctl_stall_o <= 1'b0;
      if (ctl_st_r == C_MC) begin
        if (ctl_wvld_i) begin
          mc_sh_r <= mc_word;
          mc_b_r  <= (mc_b_r == 3'd5) ? 3'd0 : mc_b_r + 3'd1;
          if (mc_wr) begin
            mc_e_r <= mc_e_r + 1'b1;
            if ({14'h0000, mc_e_r} == mc_cnt_r - 16'h0001) begin
              ctl_done_o <= 1'b1;
              ctl_st_r   <= C_IDLE;
            end
          end
        end
      end else if (setup_vld_i) begin
        ctl_rlen_o  <= 3'h0;
        ctl_rdata_o <= 48'h000000000000;
        ctl_done_o  <= 1'b1;
        case (req)
          {`RT_DEV_IN, `RQ_GET_STAT}: begin
            ctl_rdata_o <= {46'h000000000000, rwake_o, spwr_s};
            ctl_rlen_o  <= `LEN_STAT;
          end
          {`RT_IF_IN, `RQ_GET_STAT}, {`RT_EP_IN, `RQ_GET_STAT}: begin
            ctl_rlen_o <= `LEN_STAT;
          end
          {`RT_DEV_OUT, `RQ_CLR_FEAT}, {`RT_DEV_OUT, `RQ_SET_FEAT}: begin
            if (w_value_i == `FEAT_RWAKE) begin
              rwake_o <= (b_req_i == `RQ_SET_FEAT);
            end else begin
              ctl_done_o  <= 1'b0;
              ctl_stall_o <= 1'b1;
            end
          end
          {`RT_EP_OUT, `RQ_CLR_FEAT}, {`RT_EP_OUT, `RQ_SET_FEAT}: begin
            ctl_rlen_o <= 3'h0;
          end
          {`RT_DEV_OUT, `RQ_SET_ADDR}: begin
            if (w_value_i != 16'h0000 && w_value_i <= `ADDR_MAX) begin
              dev_addr_o <= w_value_i[6:0];
            end else begin
              ctl_done_o  <= 1'b0;
              ctl_stall_o <= 1'b1;
            end
          end
          {`RT_DEV_IN, `RQ_GET_CFG}: begin
            ctl_rdata_o <= {47'h000000000000, cfg_o};
            ctl_rlen_o  <= `LEN_CFG;
          end
          {`RT_DEV_OUT, `RQ_SET_CFG}: begin
            if (w_value_i <= `CFG_MAX) begin
              cfg_o <= w_value_i[0];
            end else begin
              ctl_done_o  <= 1'b0;
              ctl_stall_o <= 1'b1;
            end
          end
          {`RT_CLS_OUT, `RQ_MCAST}: begin
            if (w_value_i <= `MC_N && w_length_i == w_value_i * `MAC_BYTES) begin
              mc_cnt_r <= w_value_i;
              mc_b_r   <= 3'h0;
              mc_e_r   <= {`MC_AW{1'b0}};
              if (w_value_i != 16'h0000) begin
                ctl_done_o <= 1'b0;
                ctl_st_r   <= C_MC;
              end
            end else begin
              ctl_done_o  <= 1'b0;
              ctl_stall_o <= 1'b1;
            end
          end
          {`RT_CLS_OUT, `RQ_PKT_FLT}: begin
            pf_r <= w_value_i;
          end
          {`RT_CLS_IN, `RQ_STAT}: begin
            ctl_rlen_o <= `LEN_CNT;
            case (w_value_i)
              `STAT_TX_OK:  ctl_rdata_o <= {16'h0000, st_tx_r};
              `STAT_RX_OK:  ctl_rdata_o <= {16'h0000, st_rx_r};
              `STAT_RX_CRC: ctl_rdata_o <= {16'h0000, st_crc_r};
              default:      ctl_rdata_o <= 48'h000000000000;
            endcase
          end
          {`RT_VND_IN, `RQ_CHIP_ID}: begin
            ctl_rdata_o <= CHIP_ID;
            ctl_rlen_o  <= `LEN_ID;
          end
          default: begin
            ctl_done_o  <= 1'b0;
            ctl_stall_o <= 1'b1;
          end
        endcase
      end
    end
  end

  // PHY status, suspend and remote wake
  reg [18:0] idle_r;
  reg        link_ref_r;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle_r     <= 19'h00000;
      link_ref_r <= 1'b0;
      suspend_o  <= 1'b0;
      resume_o   <= 1'b0;
      phy_pwr_o  <= 1'b1;
      speed100_o <= 1'b0;
      full_dup_o <= 1'b0;
      pol_fix_o  <= 1'b0;
      mdix_en_o  <= 1'b1;
    end else if (ce_i) begin
      speed100_o <= pin_s[`SY_SPD];
      full_dup_o <= pin_s[`SY_FDX];
      pol_fix_o  <= ~pin_s[`SY_SPD] & pin_s[`SY_POLR];
      mdix_en_o  <= 1'b1;
      phy_pwr_o  <= ~suspend_o | (spwr_s & rwake_o);
      if (act_s) begin
        idle_r    <= 19'h00000;
        suspend_o <= 1'b0;
        resume_o  <= 1'b0;
      end else if (!suspend_o) begin
        idle_r <= idle_r + 19'h00001;
        if (idle_r == SUSP_CYC - 19'h00001) begin
          suspend_o  <= 1'b1;
          link_ref_r <= link_s;
        end
      end else if (spwr_s && rwake_o && (magic_ev || link_s != link_ref_r)) begin
        resume_o <= 1'b1;
      end
    end
  end
endmodule

// ---- verif/eth_func_wake_asserts.sv ----
// Port assertions for eth_func_wake
`timescale 1ns/100ps
module eth_func_wake_asserts #(
  parameter [18:0] SUSP_CYC = 19'd50
) (
  input wire clk_i, rstn_i, setup_vld_i, bus_act_i, ctl_done_o, ctl_stall_o, rwake_o,
  input wire pol_fix_o, speed100_o, mdix_en_o, phy_pwr_o, suspend_o, resume_o,
  input wire [7:0] bm_req_type_i, b_req_i,
  input wire [15:0] w_value_i,
  input wire [2:0] ctl_rlen_o
);
  reg [19:0] idle_r;
  wire dev_wr = setup_vld_i && bm_req_type_i == 8'h00;
  always @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
      idle_r <= 20'h0;
    else
      idle_r <= bus_act_i ? 20'h0 : idle_r + 20'h1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  AST_MDIX: assert property (mdix_en_o) else $error("mdix");
  AST_POLFIX: assert property (pol_fix_o |-> !speed100_o) else $error("polfix");
  AST_GETSTAT: assert property (setup_vld_i && bm_req_type_i == 8'h80 && b_req_i == 8'h00
    |=> ctl_done_o && ctl_rlen_o == 3'h2) else $error("status");
  AST_ADDR: assert property (dev_wr && b_req_i == 8'h05 && (w_value_i == 16'h0 || w_value_i > 16'h7f)
    |=> ctl_stall_o && !ctl_done_o) else $error("addr");
  AST_RWAKE: assert property (dev_wr && b_req_i == 8'h03 && w_value_i == 16'h1
    |-> ##[1:2] rwake_o) else $error("rwake");
  AST_RESUME: assert property ($rose(resume_o) |-> suspend_o && rwake_o) else $error("resume");
  AST_PHYOFF: assert property (suspend_o && $past(suspend_o) && !rwake_o && !$past(rwake_o)
    |-> !phy_pwr_o) else $error("phy");
  AST_SUSP: assert property ($rose(suspend_o) |-> idle_r >= SUSP_CYC) else $error("susp");
endmodule

// ---- verif/phy_peer.sv ----
// Link-side model taking transmit bytes
`timescale 1ns/100ps
module phy_peer (
  input  wire        clk_i,
  input  wire        rstn_i,
  input  wire        slow_i,
  input  wire        tx_en_i,
  input  wire [7:0]  tx_data_i,
  output reg         tx_ack_o,
  output reg  [31:0] tail_o
);
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_ack_o <= 1'b0;
      tail_o   <= 32'h0;
    end else begin
      if (tx_en_i && tx_ack_o)
        tail_o <= {tx_data_i, tail_o[31:8]};
      tx_ack_o <= slow_i ? ~tx_ack_o : 1'b1;
    end
  end
endmodule

// ---- verif/eth_func_wake_tb_top.sv ----
// Self-checking bench for eth_func_wake
`timescale 1ns/100ps
module eth_func_wake_tb_top;
  reg clk_i, rstn_i, ce_i, link_up_i, bus_act_i, self_pwr_i, pol_rev_i, an_spd100_i, an_fdx_i, pause_honor_i;
  reg setup_vld_i, ctl_wvld_i, tx_vld_i, tx_last_i, rx_dv_i, slow;
  reg [7:0] bm_req_type_i, b_req_i, ctl_wdata_i, tx_data_i, rx_data_i, fr [0:127];
  reg [15:0] w_value_i, w_length_i;
  reg [47:0] mac_addr_i;
  wire ctl_done_o, ctl_stall_o, cfg_o, tx_rdy_o, tx_en_o, tx_ack_i, rx_acc_o, rx_err_o, speed100_o, full_dup_o;
  wire pol_fix_o, mdix_en_o, phy_pwr_o, suspend_o, resume_o, rwake_o;
  wire [47:0] ctl_rdata_o;
  wire [2:0] ctl_rlen_o;
  wire [6:0] dev_addr_o;
  wire [7:0] tx_data_o;
  wire [15:0] rx_csum_o;
  wire [31:0] tail;
  integer seed = 10772, n_fail = 0, n_checks = 0, cyc = 0, i, n, a, flen = 30;
  eth_func_wake #(.SUSP_CYC(19'd50), .PAUSE_SLOT10(13'd20)) dut (.*);
  phy_peer peer (.clk_i(clk_i), .rstn_i(rstn_i), .slow_i(slow), .tx_en_i(tx_en_o), .tx_data_i(tx_data_o),
    .tx_ack_o(tx_ack_i), .tail_o(tail));
  task chk(input [47:0] s, input [47:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task tk(input integer k);
    begin
      repeat (k) @(posedge clk_i);
      #1;
    end
  endtask
  task ctl(input [7:0] t, input [7:0] r, input [15:0] v, input [15:0] l, input st);
    begin
      {bm_req_type_i, b_req_i, w_value_i, w_length_i, setup_vld_i} = {t, r, v, l, 1'b1};
      tk(1);
      setup_vld_i = 0;
      if (r != 8'h40 || st) chk({ctl_done_o, ctl_stall_o}, {~st, st});
      tk(1);
    end
  endtask
  function [31:0] crc(input integer len);
    integer p, q;
    reg [31:0] c;
    begin
      c = 32'hffffffff;
      for (p = 0; p < len; p = p + 1) begin
        c = c ^ fr[p];
        for (q = 0; q < 8; q = q + 1) c = (c >> 1) ^ (c[0] ? 32'hedb88320 : 32'h0);
      end
      crc = ~c;
    end
  endfunction
  function [15:0] csum(input integer len);
    integer p;
    reg [31:0] s;
    begin
      s = 0;
      for (p = 14; p + 1 < len; p = p + 2) s = s + {fr[p], fr[p + 1]};
      s = s[15:0] + s[31:16];
      s = s[15:0] + s[31:16];
      csum = ~s[15:0];
    end
  endfunction
  task mkfr(input [47:0] da);
    for (n = 0; n < 30; n = n + 1) fr[n] = n < 6 ? da[47 - 8 * n -: 8] : $random(seed);
  endtask
  task rx(input bad, input acc);
    reg [31:0] f;
    begin
      f = crc(flen) ^ bad;
      for (n = 0; n < flen + 4; n = n + 1) begin
        {rx_dv_i, rx_data_i} = {1'b1, n < flen ? fr[n] : f[8 * (n - flen) +: 8]};
        tk(1);
      end
      rx_dv_i = 0;
      tk(1);
      chk({rx_acc_o, rx_err_o}, {acc & ~bad, bad});
      chk(rx_csum_o, csum(flen));
    end
  endtask
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      conclude;
    end
  end
  initial begin
    {rstn_i, setup_vld_i, ctl_wvld_i, tx_vld_i, tx_last_i, rx_dv_i, an_spd100_i, slow} = 0;
    {bm_req_type_i, b_req_i, w_value_i, w_length_i, ctl_wdata_i, tx_data_i, rx_data_i} = 0;
    {ce_i, link_up_i, bus_act_i, self_pwr_i, pause_honor_i, pol_rev_i} = 6'h3f;
    an_fdx_i = $random(seed);
    mac_addr_i = {$random(seed), $random(seed)} & 48'hfeffffffffff;
    tk(6);
    rstn_i = 1;
    chk({mdix_en_o, phy_pwr_o, suspend_o}, 3'h6);
    tk(8);
    chk({pol_fix_o, speed100_o, full_dup_o}, {2'b10, an_fdx_i});
    ctl(8'h80, 8'h00, 0, 2, 0);
    chk({ctl_rlen_o, ctl_rdata_o[1:0]}, 5'h09);
    ctl(8'h00, 8'h03, 1, 0, 0);
    ctl(8'h80, 8'h00, 0, 2, 0);
    chk(ctl_rdata_o[1:0], 2'h3);
    ctl(8'h00, 8'h03, 2, 0, 1);
    for (i = 0; i < 6; i = i + 1) begin
      a = i > 3 ? $random(seed) & 255 : (i < 2 ? i : 125 + i);
      ctl(8'h00, 8'h05, a, 0, a == 0 || a > 127);
      if (a > 0 && a < 128) chk(dev_addr_o, a);
    end
    for (i = 0; i < 3; i = i + 1) begin
      ctl(8'h00, 8'h09, i, 0, i > 1);
      chk(cfg_o, i != 0);
    end
    ctl(8'hc0, 8'hff, 0, 6, 0);
    chk(ctl_rlen_o, 6);
    ctl(8'h80, 8'h06, 16'h100, 18, 1);
    ctl(8'h21, 8'h40, 5, 30, 1);
    ctl(8'h21, 8'h40, 1, 6, 0);
    for (i = 0; i < 6; i = i + 1) begin
      {ctl_wdata_i, ctl_wvld_i} = {8'h01, 8'h00, 8'h5e, 8'h0a, 8'h0b, 8'h0c} >> (8 * (5 - i)) << 1 | 1;
      tk(1);
    end
    ctl_wvld_i = 0;
    chk(ctl_done_o, 1);
    mkfr(mac_addr_i);
    rx(0, 1);
    mkfr(mac_addr_i);
    rx(1, 0);
    mkfr(mac_addr_i ^ 48'h1);
    rx(0, 0);
    mkfr(48'h01005e0a0b0c);
    rx(0, 1);
    ctl(8'h21, 8'h43, 16'h0008, 0, 0);
    mkfr(mac_addr_i);
    rx(0, 0);
    slow = 1;
    link_up_i = 0;
    tk(6);
    for (n = 0; n < 20; n = n + 1) begin
      {tx_vld_i, tx_data_i, tx_last_i} = {1'b1, fr[n], n == 19};
      while (!tx_rdy_o) tk(1);
      tk(1);
      if (n == 15) begin
        tx_vld_i = 0;
        tk(1);
        chk(tx_rdy_o, 0);
        link_up_i = 1;
      end
    end
    tx_vld_i = 0;
    for (a = 0; a < 300 && tx_en_o !== 1'b0; a = a + 1) tk(1);
    chk(tail, crc(20));
    ctl(8'ha1, 8'h44, 1, 4, 0);
    chk({ctl_rlen_o, ctl_rdata_o[31:0]}, {3'h4, 32'h1});
    mkfr(48'h0180c2000001);
    {fr[12], fr[13], fr[14], fr[15], fr[16], fr[17]} = 48'h880800010003;
    rx(0, 0);
    a = tail;
    {tx_vld_i, tx_data_i, tx_last_i} = {1'b1, fr[0], 1'b1};
    tk(1);
    tx_vld_i = 0;
    tk(40);
    chk(tail, a[31:0]);
    tk(50);
    chk(tail, crc(1));
    bus_act_i = 0;
    tk(70);
    chk({suspend_o, phy_pwr_o, resume_o}, 3'h6);
    link_up_i = 0;
    tk(8);
    chk(resume_o, 1);
    bus_act_i = 1;
    tk(8);
    bus_act_i = 0;
    tk(70);
    chk({suspend_o, resume_o}, 2'h2);
    flen = 120;
    mkfr(mac_addr_i);
    for (n = 17; n < 120; n = n + 1) fr[n] = n < 23 ? 8'hff : mac_addr_i[47 - 8 * ((n - 23) % 6) -: 8];
    rx(0, 0);
    tk(1);
    chk(resume_o, 1);
    bus_act_i = 1;
    tk(8);
    ctl(8'h00, 8'h01, 1, 0, 0);
    chk({suspend_o, resume_o, rwake_o}, 0);
    bus_act_i = 0;
    tk(70);
    chk({suspend_o, phy_pwr_o}, 2'h2);
    link_up_i = 1;
    tk(8);
    chk(resume_o, 0);
    conclude;
  end
endmodule
bind eth_func_wake eth_func_wake_asserts #(.SUSP_CYC(SUSP_CYC)) chk_u (.*);
